// file: test/timer16_normal_ctc_fast_pwm_bench.sv
// Self-checking bench: register calls over Avalon-MM, waveform timing on pin A.
// Assumes the checker binds itself to the design; prescaler N=1 unless noted.
`timescale 1ns/1ps
`default_nettype none
module timer16_normal_ctc_fast_pwm_bench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] adr = 3'h0;
  logic rdq = 1'b0;
  logic wrq = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  wire [31:0] rdat;
  wire wait_o, pa, pa_oe, pb, pb_oe;
  logic [15:0] q; // Read data of the last transfer, read or write.
  integer errors = 0;
  integer num_checks = 0;
  integer n, i;
  logic [15:0] tops [0:3] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h0020};
  logic [3:0] modes [0:3] = '{4'h5, 4'h6, 4'h7, 4'hE};
  always #25 clk_sys_i = ~clk_sys_i;
  tmr16_timer dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
    .avs_read_i(rdq), .avs_write_i(wrq), .avs_byteenable_i(4'h3), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .pin_chan_a_o(pa),
    .pin_chan_a_oe_o(pa_oe), .pin_chan_b_o(pb), .pin_chan_b_oe_o(pb_oe));
  // One bus transfer; held until waitrequest is sampled low, then released.
  task xfer(input logic w, input logic [2:0] a, input logic [15:0] d);
    begin
      adr <= a;
      wdat <= {16'h0000, d};
      wrq <= w;
      rdq <= ~w;
      @(posedge clk_sys_i);
      while (wait_o !== 1'b0) @(posedge clk_sys_i); // Only the watchdog ends a wait.
      q = rdat[15:0];
      wrq <= 1'b0;
      rdq <= 1'b0;
      @(posedge clk_sys_i); // A spare edge keeps strobes from being set twice in one step.
    end
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("FAIL %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rd_chk(input string nm, input logic [2:0] a, input logic [15:0] e);
    begin
      xfer(1'b0, a, 16'h0000);
      chk(nm, e, q);
    end
  endtask
  // Length of one full phase of pin A at level lvl, in clocks; partial phases skipped.
  task meas(input logic lvl, output integer len);
    integer k;
    begin
      k = 0;
      len = 0;
      while (pa === lvl && k < 2000) begin @(posedge clk_sys_i); k = k + 1; end
      while (pa !== lvl && k < 4000) begin @(posedge clk_sys_i); k = k + 1; end
      while (pa === lvl && len < 2000) begin @(posedge clk_sys_i); len = len + 1; end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Watchdog: the whole run needs well under 40000 clocks.
  initial begin
    #2000000;
    errors = errors + 1;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (i = 0; i < 8; i = i + 1) rd_chk("reset", i[2:0], 16'h0000);
    xfer(1'b1, 3'h7, 16'hFFFF);
    rd_chk("unmapped", 3'h7, 16'h0000);
    xfer(1'b1, 3'h6, 16'h0003);
    xfer(1'b1, 3'h2, 16'h8000);
    xfer(1'b1, 3'h3, 16'h8000);
    xfer(1'b1, 3'h1, 16'hFFF0);
    xfer(1'b1, 3'h0, 16'h0100);
    repeat (40) @(posedge clk_sys_i);
    xfer(1'b1, 3'h0, 16'h0000);
    rd_chk("ovf", 3'h5, 16'h0001);
    xfer(1'b0, 3'h1, 16'h0000);
    chk("wrap", 16'h0001, {15'h0000, q < 16'h0040});
    xfer(1'b1, 3'h5, 16'h000F);
    rd_chk("w1c", 3'h5, 16'h0000);
    xfer(1'b1, 3'h1, 16'h0005);
    xfer(1'b1, 3'h0, 16'h0101);
    repeat (20) @(posedge clk_sys_i);
    rd_chk("hold", 3'h1, 16'h0005);
    xfer(1'b1, 3'h2, 16'h0009);
    xfer(1'b1, 3'h1, 16'hFFF0);
    xfer(1'b1, 3'h0, 16'h0104);
    repeat (40) @(posedge clk_sys_i);
    rd_chk("ctc_flags", 3'h5, 16'h0003);
    xfer(1'b1, 3'h5, 16'h000F);
    repeat (30) @(posedge clk_sys_i);
    rd_chk("ctc_top", 3'h5, 16'h0002);
    xfer(1'b0, 3'h1, 16'h0000);
    chk("ctc_cnt", 16'h0001, {15'h0000, q < 16'h000A});
    xfer(1'b1, 3'h0, 16'h1914);
    meas(1'b1, n);
    chk("half", 16'd10, n[15:0]);
    xfer(1'b1, 3'h0, 16'h1A14);
    meas(1'b1, n);
    chk("half_n8", 16'd80, n[15:0]);
    xfer(1'b1, 3'h0, 16'h0005);
    xfer(1'b1, 3'h2, 16'h1234);
    rd_chk("mask", 3'h2, 16'h0034);
    xfer(1'b1, 3'h2, 16'h0002);
    xfer(1'b1, 3'h4, 16'h0020);
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, 3'h1, 16'h0000);
      xfer(1'b1, 3'h0, 16'h0920 | {12'h000, modes[i]});
      meas(1'b0, n); // Discarded: the first low phase still uses the old compare.
      meas(1'b0, n);
      chk("low", tops[i] - 16'h0002, n[15:0]);
    end
    meas(1'b1, n);
    chk("high", 16'd3, n[15:0]);
    xfer(1'b1, 3'h0, 16'h0935);
    meas(1'b0, n);
    chk("inv_low", 16'd3, n[15:0]);
    xfer(1'b1, 3'h0, 16'h0925);
    xfer(1'b1, 3'h2, 16'h0000);
    meas(1'b1, n);
    chk("spike", 16'd1, n[15:0]);
    xfer(1'b1, 3'h2, 16'h0004);
    repeat (300) @(posedge clk_sys_i);
    xfer(1'b1, 3'h1, 16'h0000);
    xfer(1'b1, 3'h0, 16'h091F);
    meas(1'b1, n);
    chk("square", 16'd5, n[15:0]);
    xfer(1'b1, 3'h5, 16'h000F);
    repeat (20) @(posedge clk_sys_i);
    rd_chk("pwm_flags", 3'h5, 16'h0003);
    xfer(1'b1, 3'h1, 16'h0000);
    xfer(1'b1, 3'h0, 16'h010C);
    xfer(1'b1, 3'h5, 16'h000F);
    repeat (40) @(posedge clk_sys_i);
    rd_chk("ctc_cap", 3'h5, 16'h000A);
    tally_and_finish;
  end
endmodule // timer16_normal_ctc_fast_pwm_bench
`default_nettype wire

// file: test/tmr16_timer_sva.sv
// Checker for the timer block: bus handshake, readback and pin routing.
// Assumes it sees only the top ports; shadows CTRL and PORT from bus writes.
`timescale 1ns/1ps
`default_nettype none
module tmr16_timer_sva (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Bus.
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Pins.
  input wire logic pin_chan_a_o,
  input wire logic pin_chan_a_oe_o,
  input wire logic pin_chan_b_o,
  input wire logic pin_chan_b_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [12:0] ctrl_q; // Shadow of the control word.
  logic [1:0] port_q; // Shadow of the plain port levels.
  // Shadows update at the completion edge, the same edge the slave does.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q <= 13'h0000;
      port_q <= 2'h0;
    end else if (avs_write_i && !avs_waitrequest_o) begin
      if (avs_address_i == 3'h0 && avs_byteenable_i[0]) ctrl_q[7:0] <= avs_writedata_i[7:0];
      if (avs_address_i == 3'h0 && avs_byteenable_i[1]) ctrl_q[12:8] <= avs_writedata_i[12:8];
      if (avs_address_i == 3'h6 && avs_byteenable_i[0]) port_q <= avs_writedata_i[1:0];
    end
  end
  sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_done; !avs_waitrequest_o; endsequence
  property p_answer; s_req |=> s_done; endproperty
  a_answer: assert property (p_answer) else $error("request not answered in one cycle");
  property p_pulse; s_done |=> avs_waitrequest_o; endproperty
  a_pulse: assert property (p_pulse) else $error("waitrequest low too long");
  property p_idle; !(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_upper; s_done |-> avs_readdata_o[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  property p_unmapped; s_done and avs_read_i && avs_address_i == 3'h7 |->
    avs_readdata_o == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_ctrl; s_done and avs_read_i && avs_address_i == 3'h0 |->
    avs_readdata_o[12:0] == ctrl_q; endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
  property p_oe_a; pin_chan_a_oe_o == $past(ctrl_q[11]); endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin A enable wrong");
  property p_oe_b; pin_chan_b_oe_o == $past(ctrl_q[12]); endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin B enable wrong");
  property p_port_a; $past(ctrl_q[5:4]) == 2'h0 |-> pin_chan_a_o == $past(port_q[0]);
  endproperty
  a_port_a: assert property (p_port_a) else $error("pin A not port level");
  property p_port_b; $past(ctrl_q[7:6]) == 2'h0 |-> pin_chan_b_o == $past(port_q[1]);
  endproperty
  a_port_b: assert property (p_port_b) else $error("pin B not port level");
endmodule // tmr16_timer_sva
bind tmr16_timer tmr16_timer_sva u_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .pin_chan_a_o(pin_chan_a_o), .pin_chan_a_oe_o(pin_chan_a_oe_o),
  .pin_chan_b_o(pin_chan_b_o), .pin_chan_b_oe_o(pin_chan_b_oe_o));
`default_nettype wire

// file: verilog/tmr16_defs.vh
// Constants for the 16-bit timer/counter block: register word indices,
// control field positions, reset values, mode codes and prescaler factors.
// Assumes it is included by bare name from the design file only.
`ifndef TMR16_DEFS_VH
`define TMR16_DEFS_VH

// Register word indices; the byte address is four times the index.
`define TMR16_REG_CTRL 3'h0
`define TMR16_REG_COUNT 3'h1
`define TMR16_REG_CMPA 3'h2
`define TMR16_REG_CMPB 3'h3
`define TMR16_REG_CAPTOP 3'h4
`define TMR16_REG_FLAGS 3'h5
`define TMR16_REG_PORT 3'h6

// Control register field positions.
`define TMR16_CTRL_MODE_LSB 0
`define TMR16_CTRL_MODE_MSB 3
`define TMR16_CTRL_ACTA_LSB 4
`define TMR16_CTRL_ACTA_MSB 5
`define TMR16_CTRL_ACTB_LSB 6
`define TMR16_CTRL_ACTB_MSB 7
`define TMR16_CTRL_PSC_LSB 8
`define TMR16_CTRL_PSC_MSB 10
`define TMR16_CTRL_DIRA_BIT 11
`define TMR16_CTRL_DIRB_BIT 12

// Flag register bit positions.
`define TMR16_FLAG_OVF_BIT 0
`define TMR16_FLAG_CMPA_BIT 1
`define TMR16_FLAG_CMPB_BIT 2
`define TMR16_FLAG_CAP_BIT 3

// Reset values.
`define TMR16_RST_CTRL 13'h0000
`define TMR16_RST_WORD 16'h0000

// Waveform mode select codes handled by this block.
`define TMR16_MODE_NORMAL 4'h0
`define TMR16_MODE_CTC_CMPA 4'h4
`define TMR16_MODE_FPWM_8 4'h5
`define TMR16_MODE_FPWM_9 4'h6
`define TMR16_MODE_FPWM_10 4'h7
`define TMR16_MODE_CTC_CAP 4'hC
`define TMR16_MODE_FPWM_CAP 4'hE
`define TMR16_MODE_FPWM_CMPA 4'hF

// Counter extremes and fixed tops.
`define TMR16_MAX 16'hFFFF
`define TMR16_BOTTOM 16'h0000
`define TMR16_TOP_8 16'h00FF
`define TMR16_TOP_9 16'h01FF
`define TMR16_TOP_10 16'h03FF

// Output action codes.
`define TMR16_ACT_OFF 2'h0
`define TMR16_ACT_TOGGLE 2'h1
`define TMR16_ACT_CLEAR 2'h2
`define TMR16_ACT_SET 2'h3

// Prescaler selects and the division factor minus one for each.
`define TMR16_PSC_STOP 3'h0
`define TMR16_PSC_1 3'h1
`define TMR16_PSC_8 3'h2
`define TMR16_PSC_64 3'h3
`define TMR16_PSC_256 3'h4
`define TMR16_PSC_1024 3'h5
`define TMR16_DIV_1 10'h000
`define TMR16_DIV_8 10'h007
`define TMR16_DIV_64 10'h03F
`define TMR16_DIV_256 10'h0FF
`define TMR16_DIV_1024 10'h3FF

`endif

// file: verilog/tmr16_timer.v
// 16-bit timer/counter with normal, clear-on-match and fast PWM modes,
// two compare channels with waveform outputs, and an Avalon-MM slave.
// Assumes one 20 MHz clock, a synchronous active-low reset, and a master
// that holds each request until it samples waitrequest low.
//
// How it works
// - Normal mode counts up and wraps at 0xFFFF.
// - Normal mode sets overflow when count becomes zero.
// - Modes 4/12 clear on compare A/capture top.
// - Clear-on-match top unbuffered; late top wraps first.
// - Clear-on-match sets the top register's flag.
// - Action 1 toggles output A on match.
// - Clear-on-match still flags overflow at MAX-to-zero.
// - Fast PWM tops: fixed, capture or compare A.
// - Fast PWM clears the cycle after reaching top.
// - Action 2 clear-match/set-bottom; 3 the opposite.
// - Fast PWM sets overflow at top, not MAX.
// - Top register's flag rises with fast PWM overflow.
// - Fixed tops mask compare writes to width.
// - Capture top unbuffered in fast PWM.
// - Fast PWM compare A buffered, loaded at top.
// - Compare zero spikes; compare at top holds constant.
// - Mode 15 action 1 gives a square wave.
// - Actions shape outputs only, never counting.
// - Pin driven only while direction bit selects output.
// - Timer clock is I/O clock over N.
// - Action zero leaves output state untouched.
// - Count write blocks matches for one timer cycle.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`include "tmr16_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module tmr16_timer (
  // Clock and reset.
  input wire clk_sys_i,
  input wire rst_n_i,
  // Avalon-MM slave, word addressed.
  input wire [2:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // Waveform pins, two signals each.
  output reg pin_chan_a_o,
  output reg pin_chan_a_oe_o,
  output reg pin_chan_b_o,
  output reg pin_chan_b_oe_o
);

  // Software-visible state.
  reg [3:0] waveform_mode_select; // Chooses the counting sequence.
  reg [1:0] output_action_select_chan_a; // Output action for channel A.
  reg [1:0] output_action_select_chan_b; // Output action for channel B.
  reg [2:0] prescale_select; // Zero stops the timer clock.
  reg pin_direction_bit_chan_a; // One lets channel A drive its pin.
  reg pin_direction_bit_chan_b; // One lets channel B drive its pin.
  reg [1:0] port_value; // Ordinary port level when no override.
  reg [15:0] count_value; // The counter itself.
  reg [15:0] compare_value_chan_a; // Active compare A.
  reg [15:0] compare_buf_chan_a; // Compare A as last written.
  reg [15:0] compare_value_chan_b; // Active compare B.
  reg [15:0] compare_buf_chan_b; // Compare B as last written.
  reg [15:0] capture_top_value; // Capture register used as a top.
  reg overflow_flag; // Sticky overflow indication.
  reg compare_match_flag_chan_a; // Sticky compare A indication.
  reg compare_match_flag_chan_b; // Sticky compare B indication.
  reg capture_event_flag; // Sticky capture-top indication.
  reg waveform_output_chan_a; // Internal output state A, kept across modes.
  reg waveform_output_chan_b; // Internal output state B.
  reg match_blocked; // Set by a count write, eats the next timer cycle's matches.

  // Prescaler state.
  reg [9:0] psc_count; // Free divider count.
  reg [9:0] psc_limit; // Factor minus one for the chosen select.
  reg timer_tick; // One-cycle enable that clocks the timer.

  // Bus decode helpers.
  wire bus_take; // The edge at which a request completes.
  wire wr_ctrl;
  wire wr_count;
  wire wr_cmpa;
  wire wr_cmpb;
  wire wr_captop;
  wire wr_flags;
  wire wr_port;
  assign bus_take = ~avs_waitrequest_o & (avs_read_i | avs_write_i);
  assign wr_ctrl = bus_take & avs_write_i & (avs_address_i == `TMR16_REG_CTRL);
  assign wr_count = bus_take & avs_write_i & (avs_address_i == `TMR16_REG_COUNT);
  assign wr_cmpa = bus_take & avs_write_i & (avs_address_i == `TMR16_REG_CMPA);
  assign wr_cmpb = bus_take & avs_write_i & (avs_address_i == `TMR16_REG_CMPB);
  assign wr_captop = bus_take & avs_write_i & (avs_address_i == `TMR16_REG_CAPTOP);
  assign wr_flags = bus_take & avs_write_i & (avs_address_i == `TMR16_REG_FLAGS);
  assign wr_port = bus_take & avs_write_i & (avs_address_i == `TMR16_REG_PORT);

  // Merges the two low byte lanes of a write into a 16-bit register.
  function [15:0] lane_merge;
    input [15:0] old_val;
    input [31:0] new_val;
    input [3:0] be;
    begin
      lane_merge[7:0] = be[0] ? new_val[7:0] : old_val[7:0];
      lane_merge[15:8] = be[1] ? new_val[15:8] : old_val[15:8];
    end
  endfunction

  // Next internal output state for one channel.
  function wave_next;
    input cur;
    input [1:0] act;
    input pwm;
    input toggle_ok;
    input match;
    input wrap;
    begin
      wave_next = cur;
      if (act == `TMR16_ACT_OFF) begin
        wave_next = cur;
      end else if (!pwm) begin
        if (match) begin
          case (act)
            `TMR16_ACT_TOGGLE: wave_next = ~cur;
            `TMR16_ACT_CLEAR: wave_next = 1'b0;
            default: wave_next = 1'b1;
          endcase
        end
      end else begin
        case (act)
          `TMR16_ACT_TOGGLE: wave_next = (toggle_ok & match) ? ~cur : cur;
          // Bottom wins over a match in the same cycle, so a compare at
          // top gives a constant level and a compare of zero a spike.
          `TMR16_ACT_CLEAR: wave_next = wrap ? 1'b1 : (match ? 1'b0 : cur);
          default: wave_next = wrap ? 1'b0 : (match ? 1'b1 : cur);
        endcase
      end
    end
  endfunction

  // Mode decoding and top selection; only the mode field matters here.
  reg mode_normal;
  reg mode_ctc;
  reg mode_fpwm;
  reg top_is_cmpa;
  reg top_is_cap;
  reg [15:0] top_value;
  reg [15:0] write_mask;
  always @* begin
    mode_normal = 1'b0;
    mode_ctc = 1'b0;
    mode_fpwm = 1'b0;
    top_is_cmpa = 1'b0;
    top_is_cap = 1'b0;
    top_value = `TMR16_MAX;
    write_mask = `TMR16_MAX;
    case (waveform_mode_select)
      `TMR16_MODE_NORMAL: begin
        mode_normal = 1'b1;
      end
      `TMR16_MODE_CTC_CMPA: begin
        mode_ctc = 1'b1;
        top_is_cmpa = 1'b1;
        top_value = compare_value_chan_a;
      end
      `TMR16_MODE_CTC_CAP: begin
        mode_ctc = 1'b1;
        top_is_cap = 1'b1;
        top_value = capture_top_value;
      end
      `TMR16_MODE_FPWM_8: begin
        mode_fpwm = 1'b1;
        top_value = `TMR16_TOP_8;
        write_mask = `TMR16_TOP_8;
      end
      `TMR16_MODE_FPWM_9: begin
        mode_fpwm = 1'b1;
        top_value = `TMR16_TOP_9;
        write_mask = `TMR16_TOP_9;
      end
      `TMR16_MODE_FPWM_10: begin
        mode_fpwm = 1'b1;
        top_value = `TMR16_TOP_10;
        write_mask = `TMR16_TOP_10;
      end
      `TMR16_MODE_FPWM_CAP: begin
        mode_fpwm = 1'b1;
        top_is_cap = 1'b1;
        top_value = capture_top_value;
      end
      `TMR16_MODE_FPWM_CMPA: begin
        mode_fpwm = 1'b1;
        top_is_cmpa = 1'b1;
        top_value = compare_value_chan_a;
      end
      default: begin
        top_value = `TMR16_MAX;
      end
    endcase
  end

  // Counting sequence and events for one timer tick. A top that software
  // moved below the count is simply passed, so the counter runs to MAX.
  reg mode_runs;
  reg hit_top;
  reg match_a;
  reg match_b;
  reg top_clear;
  reg [15:0] next_count;
  reg ovf_set;
  reg cmpa_set;
  reg cmpb_set;
  reg cap_set;
  always @* begin
    mode_runs = mode_normal | mode_ctc | mode_fpwm;
    hit_top = (count_value == top_value) & ~match_blocked;
    match_a = (count_value == compare_value_chan_a) & ~match_blocked;
    match_b = (count_value == compare_value_chan_b) & ~match_blocked;
    top_clear = (mode_ctc | mode_fpwm) & hit_top;
    if (top_clear) begin
      next_count = `TMR16_BOTTOM;
    end else begin
      next_count = count_value + 16'h0001;
    end
    ovf_set = timer_tick & mode_runs &
              (mode_fpwm ? hit_top : (count_value == `TMR16_MAX));
    cmpa_set = timer_tick & mode_runs &
               (match_a | (top_clear & top_is_cmpa));
    cmpb_set = timer_tick & mode_runs & match_b;
    cap_set = timer_tick & mode_runs & top_clear & top_is_cap;
  end

  // Prescaler: the divider runs free and the select picks its length.
  always @* begin
    case (prescale_select)
      `TMR16_PSC_1: psc_limit = `TMR16_DIV_1;
      `TMR16_PSC_8: psc_limit = `TMR16_DIV_8;
      `TMR16_PSC_64: psc_limit = `TMR16_DIV_64;
      `TMR16_PSC_256: psc_limit = `TMR16_DIV_256;
      `TMR16_PSC_1024: psc_limit = `TMR16_DIV_1024;
      default: psc_limit = `TMR16_DIV_1;
    endcase
  end

  // Divider counter and the timer tick; stop or invalid selects stall it.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      psc_count <= 10'h000;
      timer_tick <= 1'b0;
    end else if (prescale_select == `TMR16_PSC_STOP ||
                 prescale_select > `TMR16_PSC_1024) begin
      psc_count <= 10'h000;
      timer_tick <= 1'b0;
    end else if (psc_count >= psc_limit) begin
      psc_count <= 10'h000;
      timer_tick <= 1'b1;
    end else begin
      psc_count <= psc_count + 10'h001;
      timer_tick <= 1'b0;
    end
  end

  // Avalon handshake: each request is answered one cycle after it appears,
  // with waitrequest low for exactly that one cycle.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_waitrequest_o && (avs_read_i || avs_write_i)) begin
      avs_waitrequest_o <= 1'b0;
      case (avs_address_i)
        `TMR16_REG_CTRL: avs_readdata_o <= {19'h0_0000, pin_direction_bit_chan_b,
          pin_direction_bit_chan_a, prescale_select, output_action_select_chan_b,
          output_action_select_chan_a, waveform_mode_select};
        `TMR16_REG_COUNT: avs_readdata_o <= {16'h0000, count_value};
        `TMR16_REG_CMPA: avs_readdata_o <= {16'h0000, compare_buf_chan_a};
        `TMR16_REG_CMPB: avs_readdata_o <= {16'h0000, compare_buf_chan_b};
        `TMR16_REG_CAPTOP: avs_readdata_o <= {16'h0000, capture_top_value};
        `TMR16_REG_FLAGS: avs_readdata_o <= {28'h000_0000, capture_event_flag,
          compare_match_flag_chan_b, compare_match_flag_chan_a, overflow_flag};
        `TMR16_REG_PORT: avs_readdata_o <= {24'h00_0000, 2'h0,
          waveform_output_chan_b, waveform_output_chan_a, 2'h0, port_value};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Configuration registers written by software.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {pin_direction_bit_chan_b, pin_direction_bit_chan_a, prescale_select,
       output_action_select_chan_b, output_action_select_chan_a,
       waveform_mode_select} <= `TMR16_RST_CTRL;
      port_value <= 2'h0;
      capture_top_value <= `TMR16_RST_WORD;
    end else begin
      if (wr_ctrl && avs_byteenable_i[0]) begin
        waveform_mode_select <= avs_writedata_i[`TMR16_CTRL_MODE_MSB:`TMR16_CTRL_MODE_LSB];
        output_action_select_chan_a <= avs_writedata_i[`TMR16_CTRL_ACTA_MSB:`TMR16_CTRL_ACTA_LSB];
        output_action_select_chan_b <= avs_writedata_i[`TMR16_CTRL_ACTB_MSB:`TMR16_CTRL_ACTB_LSB];
      end
      if (wr_ctrl && avs_byteenable_i[1]) begin
        prescale_select <= avs_writedata_i[`TMR16_CTRL_PSC_MSB:`TMR16_CTRL_PSC_LSB];
        pin_direction_bit_chan_a <= avs_writedata_i[`TMR16_CTRL_DIRA_BIT];
        pin_direction_bit_chan_b <= avs_writedata_i[`TMR16_CTRL_DIRB_BIT];
      end
      if (wr_port && avs_byteenable_i[0]) begin
        port_value <= avs_writedata_i[1:0];
      end
      if (wr_captop) begin
        // Written straight through, never buffered.
        capture_top_value <= lane_merge(capture_top_value, avs_writedata_i,
                                        avs_byteenable_i);
      end
    end
  end

  // Compare registers. Outside fast PWM a write reaches the active value at
  // once; in fast PWM it waits in the buffer until the counter hits top.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      compare_buf_chan_a <= `TMR16_RST_WORD;
      compare_value_chan_a <= `TMR16_RST_WORD;
      compare_buf_chan_b <= `TMR16_RST_WORD;
      compare_value_chan_b <= `TMR16_RST_WORD;
    end else begin
      if (wr_cmpa) begin
        compare_buf_chan_a <= lane_merge(compare_buf_chan_a, avs_writedata_i,
                                         avs_byteenable_i) & write_mask;
        if (!mode_fpwm) begin
          compare_value_chan_a <= lane_merge(compare_buf_chan_a, avs_writedata_i,
                                             avs_byteenable_i) & write_mask;
        end
      end else if (mode_fpwm && timer_tick && top_clear) begin
        compare_value_chan_a <= compare_buf_chan_a;
      end
      if (wr_cmpb) begin
        compare_buf_chan_b <= lane_merge(compare_buf_chan_b, avs_writedata_i,
                                         avs_byteenable_i) & write_mask;
        if (!mode_fpwm) begin
          compare_value_chan_b <= lane_merge(compare_buf_chan_b, avs_writedata_i,
                                             avs_byteenable_i) & write_mask;
        end
      end else if (mode_fpwm && timer_tick && top_clear) begin
        compare_value_chan_b <= compare_buf_chan_b;
      end
    end
  end

  // Counter and match blocking. A software write wins over a tick in the
  // same cycle and arms the block for the next timer cycle.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      count_value <= `TMR16_RST_WORD;
      match_blocked <= 1'b0;
    end else if (wr_count) begin
      count_value <= lane_merge(count_value, avs_writedata_i, avs_byteenable_i);
      match_blocked <= 1'b1;
    end else if (timer_tick) begin
      match_blocked <= 1'b0;
      if (mode_runs) begin
        count_value <= next_count;
      end
    end
  end

  // Sticky flags: hardware sets, software clears by writing ones, and a
  // set in the clearing cycle wins so no event is lost.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      overflow_flag <= 1'b0;
      compare_match_flag_chan_a <= 1'b0;
      compare_match_flag_chan_b <= 1'b0;
      capture_event_flag <= 1'b0;
    end else begin
      overflow_flag <= ovf_set | (overflow_flag &
        ~(wr_flags & avs_byteenable_i[0] & avs_writedata_i[`TMR16_FLAG_OVF_BIT]));
      compare_match_flag_chan_a <= cmpa_set | (compare_match_flag_chan_a &
        ~(wr_flags & avs_byteenable_i[0] & avs_writedata_i[`TMR16_FLAG_CMPA_BIT]));
      compare_match_flag_chan_b <= cmpb_set | (compare_match_flag_chan_b &
        ~(wr_flags & avs_byteenable_i[0] & avs_writedata_i[`TMR16_FLAG_CMPB_BIT]));
      capture_event_flag <= cap_set | (capture_event_flag &
        ~(wr_flags & avs_byteenable_i[0] & avs_writedata_i[`TMR16_FLAG_CAP_BIT]));
    end
  end

  // Waveform state per channel; only compare A may use the toggle in PWM.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      waveform_output_chan_a <= 1'b0;
      waveform_output_chan_b <= 1'b0;
    end else if (timer_tick && mode_runs) begin
      waveform_output_chan_a <= wave_next(waveform_output_chan_a,
        output_action_select_chan_a, mode_fpwm, top_is_cmpa, match_a,
        top_clear);
      waveform_output_chan_b <= wave_next(waveform_output_chan_b,
        output_action_select_chan_b, mode_fpwm, 1'b0, match_b,
        top_clear);
    end
  end

  // Pin override: a non-zero action hands the pin to the waveform state,
  // except the toggle code in PWM where it is not supported. The enable
  // follows the direction bit alone, so the state can be set up first.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_chan_a_o <= 1'b0;
      pin_chan_a_oe_o <= 1'b0;
      pin_chan_b_o <= 1'b0;
      pin_chan_b_oe_o <= 1'b0;
    end else begin
      if (output_action_select_chan_a != `TMR16_ACT_OFF &&
          !(mode_fpwm && output_action_select_chan_a == `TMR16_ACT_TOGGLE &&
            !top_is_cmpa)) begin
        pin_chan_a_o <= waveform_output_chan_a;
      end else begin
        pin_chan_a_o <= port_value[0];
      end
      if (output_action_select_chan_b != `TMR16_ACT_OFF &&
          !(mode_fpwm && output_action_select_chan_b == `TMR16_ACT_TOGGLE)) begin
        pin_chan_b_o <= waveform_output_chan_b;
      end else begin
        pin_chan_b_o <= port_value[1];
      end
      pin_chan_a_oe_o <= pin_direction_bit_chan_a;
      pin_chan_b_oe_o <= pin_direction_bit_chan_b;
    end
  end

endmodule // tmr16_timer

`default_nettype wire
